/* File: hdl/dit_params.svh */
`ifndef DIT_PARAMS_SVH
`define DIT_PARAMS_SVH
`define DIT_CNT_W 16
`define DIT_CNT_RESET 16'h0000
`define DIT_CNT_ONE 16'h0001
`define DIT_CNT_ZERO 16'h0000
`define DIT_EV_A_BIT 4
`define DIT_EV_B_BIT 5
`define DIT_EV_W 6
`define DIT_EV_RESET 6'h00
`define DIT_STEPS_W 17
`define DIT_STEPS_RESET 17'h00000
`define DIT_STEP_ONE 17'h00001
`define DIT_FULL_PERIOD 17'h10000
`endif

/* File: hdl/dit_pkg.sv */
package dit_pkg;
  typedef logic [15:0] dit_count_t;
  typedef enum logic [1:0] {
    DIT_SEL_NONE = 2'b00,
    DIT_SEL_A = 2'b01,
    DIT_SEL_B = 2'b10
  } dit_sel_t;
endpackage : dit_pkg

/* File: hdl/dit_step_if.sv */
`timescale 1ns/1ps
interface dit_step_if;
  logic step;
  modport src (output step);
  modport dst (input step);
endinterface : dit_step_if

/* File: hdl/dit_edge_sync.sv */
`timescale 1ns/1ps
module dit_edge_sync (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic ext_clk_in,
  dit_step_if.src step_out
);
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic step_ff;

  // Two-stage synchroniser; only the second stage and its delayed copy feed the edge detector.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= ext_clk_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // One pulse per external rising edge, since it needs the second stage high while its delayed copy is still low.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      step_ff <= 1'b0;
    end else begin
      step_ff <= sync2_ff & ~sync3_ff;
    end
  end

  assign step_out.step = step_ff;
endmodule : dit_edge_sync

/* File: hdl/dit_timers.sv */
`timescale 1ns/1ps
`include "dit_params.svh"
module dit_timers (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic ext_clk_in,
  input wire logic timer_a_enable_in,
  input wire logic timer_b_enable_in,
  input wire dit_pkg::dit_sel_t wr_sel_in,
  input wire dit_pkg::dit_count_t wr_data_in,
  input wire dit_pkg::dit_sel_t rd_sel_in,
  input wire logic [5:0] event_clear_in,
  output dit_pkg::dit_count_t rd_data_out,
  output logic [5:0] sparse_event_out,
  output logic sparse_event_summary_out
);
  import dit_pkg::*;

  dit_step_if a_step ();
  dit_count_t init_a_ff;
  dit_count_t init_b_ff;
  dit_count_t count_a_ff;
  dit_count_t count_b_ff;
  dit_count_t nxt_count_a;
  dit_count_t nxt_count_b;
  dit_count_t rd_data_ff;
  logic [5:0] event_ff;
  logic summary_ff;
  logic tmo_a;
  logic tmo_b;
  logic [`DIT_STEPS_W-1:0] a_steps_ff;
  logic [`DIT_STEPS_W-1:0] b_steps_ff;

  // External clock edge detector lives in its own module for reuse.
  dit_edge_sync u_sync (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .ext_clk_in(ext_clk_in),
    .step_out(a_step)
  );

  // Timeout means an enabled step arriving while the count is one.
  assign tmo_a = timer_a_enable_in & a_step.step & (count_a_ff == `DIT_CNT_ONE);
  assign tmo_b = timer_b_enable_in & (count_b_ff == `DIT_CNT_ONE);

  // Initialization values are kept for reload after every timeout.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      init_a_ff <= `DIT_CNT_RESET;
      init_b_ff <= `DIT_CNT_RESET;
    end else begin
      if (wr_sel_in == DIT_SEL_A) begin
        init_a_ff <= wr_data_in;
      end
      if (wr_sel_in == DIT_SEL_B) begin
        init_b_ff <= wr_data_in;
      end
    end
  end

  // Next count for timer a: a write wins, then reload on timeout, then decrement.
  always_comb begin
    nxt_count_a = count_a_ff;
    if (wr_sel_in == DIT_SEL_A) begin
      nxt_count_a = wr_data_in;
    end else if (tmo_a) begin
      nxt_count_a = init_a_ff;
    end else if (timer_a_enable_in && a_step.step) begin
      // Zero wraps to all ones, which gives the full 65536-step period.
      nxt_count_a = count_a_ff - `DIT_CNT_ONE;
    end
  end

  // Next count for timer b, stepping on every processor clock edge.
  always_comb begin
    nxt_count_b = count_b_ff;
    if (wr_sel_in == DIT_SEL_B) begin
      nxt_count_b = wr_data_in;
    end else if (tmo_b) begin
      nxt_count_b = init_b_ff;
    end else if (timer_b_enable_in) begin
      nxt_count_b = count_b_ff - `DIT_CNT_ONE;
    end
  end

  // Both live counters.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      count_a_ff <= `DIT_CNT_RESET;
      count_b_ff <= `DIT_CNT_RESET;
    end else begin
      count_a_ff <= nxt_count_a;
      count_b_ff <= nxt_count_b;
    end
  end

  // Operand read path is registered, so the value is the count one cycle before it shows.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      rd_data_ff <= `DIT_CNT_RESET;
    end else begin
      case (rd_sel_in)
        DIT_SEL_A: begin
          rd_data_ff <= count_a_ff;
        end
        DIT_SEL_B: begin
          rd_data_ff <= count_b_ff;
        end
        default: begin
          rd_data_ff <= `DIT_CNT_ZERO;
        end
      endcase
    end
  end

  // Event bits stay set until firmware clears them; a set in the clear cycle wins.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      event_ff <= `DIT_EV_RESET;
    end else begin
      event_ff <= event_ff & ~event_clear_in;
      if (tmo_a) begin
        event_ff[`DIT_EV_A_BIT] <= 1'b1;
      end
      if (tmo_b) begin
        event_ff[`DIT_EV_B_BIT] <= 1'b1;
      end
    end
  end

  // Summary follows the event bits one cycle later so it comes from a flop.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      summary_ff <= 1'b0;
    end else begin
      summary_ff <= |event_ff;
    end
  end

  assign rd_data_out = rd_data_ff;
  assign sparse_event_out = event_ff;
  assign sparse_event_summary_out = summary_ff;

  // Timer b timeout latches bit five on the next edge.
  chk_b_event_set: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    tmo_b |=> event_ff[`DIT_EV_B_BIT])
    else $error("timer b timeout did not set its event bit");

  chk_a_event_set: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    tmo_a |=> event_ff[`DIT_EV_A_BIT])
    else $error("timer a timeout did not set its event bit");

  chk_b_reload: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (tmo_b && wr_sel_in != DIT_SEL_B) |=> count_b_ff == $past(init_b_ff))
    else $error("timer b did not reload");

  chk_write_load: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    wr_sel_in == DIT_SEL_A |=> count_a_ff == $past(wr_data_in) && init_a_ff == count_a_ff)
    else $error("timer a write did not load");

  chk_a_hold_off: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (!timer_a_enable_in && wr_sel_in != DIT_SEL_A) |=> $stable(count_a_ff))
    else $error("disabled timer a moved");

  chk_b_decrement: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (timer_b_enable_in && !tmo_b && wr_sel_in != DIT_SEL_B)
    |=> count_b_ff == $past(count_b_ff) - `DIT_CNT_ONE)
    else $error("timer b did not decrement");

  chk_a_one_step: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    a_step.step |=> !a_step.step)
    else $error("external edge produced two steps");

  chk_read_live: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    rd_sel_in == DIT_SEL_B |=> rd_data_out == $past(count_b_ff))
    else $error("timer b read mismatch");

  chk_summary_or: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ##1 sparse_event_summary_out == |$past(event_ff))
    else $error("summary flag mismatch");

  chk_event_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (event_ff[`DIT_EV_A_BIT] && !event_clear_in[`DIT_EV_A_BIT]) |=> event_ff[`DIT_EV_A_BIT])
    else $error("event bit dropped without clear");

  // Steps since the last load or timeout, kept only for the period checks below.
  // The count is one bit wider than a timer so that a full 65536-step period still fits.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      a_steps_ff <= `DIT_STEPS_RESET;
    end else if (wr_sel_in == DIT_SEL_A || tmo_a) begin
      a_steps_ff <= `DIT_STEPS_RESET;
    end else if (timer_a_enable_in && a_step.step) begin
      a_steps_ff <= a_steps_ff + `DIT_STEP_ONE;
    end
  end

  // Same step count for timer b, which steps on every enabled edge.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      b_steps_ff <= `DIT_STEPS_RESET;
    end else if (wr_sel_in == DIT_SEL_B || tmo_b) begin
      b_steps_ff <= `DIT_STEPS_RESET;
    end else if (timer_b_enable_in) begin
      b_steps_ff <= b_steps_ff + `DIT_STEP_ONE;
    end
  end

  // A timeout must close exactly one period of the stored value; zero stands for 65536.
  // This catches a count that skips a step or times out on the wrong value.
  chk_a_period: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (tmo_a && wr_sel_in != DIT_SEL_A)
    |-> a_steps_ff + `DIT_STEP_ONE ==
    ((init_a_ff == `DIT_CNT_ZERO) ? `DIT_FULL_PERIOD : {1'b0, init_a_ff}))
    else $error("timer a period length wrong");

  // Same period check for timer b.
  chk_b_period: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (tmo_b && wr_sel_in != DIT_SEL_B)
    |-> b_steps_ff + `DIT_STEP_ONE ==
    ((init_b_ff == `DIT_CNT_ZERO) ? `DIT_FULL_PERIOD : {1'b0, init_b_ff}))
    else $error("timer b period length wrong");

  // Timer a reloads its stored value, as timer b does.
  chk_a_reload: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (tmo_a && wr_sel_in != DIT_SEL_A) |=> count_a_ff == $past(init_a_ff))
    else $error("timer a did not reload");

  // Timer a steps down by one on each synchronised external edge.
  chk_a_decrement: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (timer_a_enable_in && a_step.step && !tmo_a && wr_sel_in != DIT_SEL_A)
    |=> count_a_ff == $past(count_a_ff) - `DIT_CNT_ONE)
    else $error("timer a did not decrement");

  // Between external edges timer a must hold, even while it is enabled.
  chk_a_step_gap: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (!a_step.step && wr_sel_in != DIT_SEL_A) |=> $stable(count_a_ff))
    else $error("timer a moved without an external edge");

  // A disabled timer b must not move.
  chk_b_hold_off: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (!timer_b_enable_in && wr_sel_in != DIT_SEL_B) |=> $stable(count_b_ff))
    else $error("disabled timer b moved");

  // A timer b write loads both the counter and the stored value.
  chk_b_write_load: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    wr_sel_in == DIT_SEL_B |=> count_b_ff == $past(wr_data_in) && init_b_ff == count_b_ff)
    else $error("timer b write did not load");

  // A timer a operand read shows the count of the select cycle.
  chk_read_a_live: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    rd_sel_in == DIT_SEL_A |=> rd_data_out == $past(count_a_ff))
    else $error("timer a read mismatch");

  // An unselected operand reads as zero.
  chk_read_none_zero: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    rd_sel_in == DIT_SEL_NONE |=> rd_data_out == `DIT_CNT_ZERO)
    else $error("unselected read not zero");

  // Event bits only rise on an enabled timeout, so a disabled timer stays silent.
  chk_a_event_cause: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (!event_ff[`DIT_EV_A_BIT] && !tmo_a) |=> !event_ff[`DIT_EV_A_BIT])
    else $error("timer a event bit rose without timeout");

  // Same for timer b.
  chk_b_event_cause: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (!event_ff[`DIT_EV_B_BIT] && !tmo_b) |=> !event_ff[`DIT_EV_B_BIT])
    else $error("timer b event bit rose without timeout");

  // The timer b event bit holds until firmware clears it.
  chk_b_event_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (event_ff[`DIT_EV_B_BIT] && !event_clear_in[`DIT_EV_B_BIT]) |=> event_ff[`DIT_EV_B_BIT])
    else $error("timer b event bit dropped without clear");

  // A clear with no timeout in the same cycle drops the bit.
  // With a timeout in that cycle the set wins, which the event set checks cover.
  chk_a_event_clear: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (event_clear_in[`DIT_EV_A_BIT] && !tmo_a) |=> !event_ff[`DIT_EV_A_BIT])
    else $error("timer a event bit not cleared");

  // Same for timer b.
  chk_b_event_clear: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (event_clear_in[`DIT_EV_B_BIT] && !tmo_b) |=> !event_ff[`DIT_EV_B_BIT])
    else $error("timer b event bit not cleared");

  // Reset clears counters, reads and events.
  // This check has no disable, since it must look at the cycles while reset is held.
  chk_reset_state: assert property (@(posedge core_clk_in)
    !rst_b_in |=> count_a_ff == `DIT_CNT_RESET && count_b_ff == `DIT_CNT_RESET
      && event_ff == `DIT_EV_RESET && rd_data_ff == `DIT_CNT_RESET && !summary_ff)
    else $error("reset state wrong");
endmodule : dit_timers

/* File: verif/test_dual_interval_timers.sv */
`timescale 1ns/1ps
module test_dual_interval_timers;
  import dit_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ext_clk_in = 1'b0;
  logic en_a = 1'b0;
  logic en_b = 1'b0;
  dit_sel_t wr_sel = DIT_SEL_NONE;
  dit_sel_t rd_sel = DIT_SEL_NONE;
  dit_count_t wr_data = 16'h0000;
  logic [5:0] ev_clr = 6'h00;
  dit_count_t rd_data;
  logic [5:0] ev;
  logic ev_sum;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  dit_timers u_dut (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .ext_clk_in(ext_clk_in),
    .timer_a_enable_in(en_a),
    .timer_b_enable_in(en_b),
    .wr_sel_in(wr_sel),
    .wr_data_in(wr_data),
    .rd_sel_in(rd_sel),
    .event_clear_in(ev_clr),
    .rd_data_out(rd_data),
    .sparse_event_out(ev),
    .sparse_event_summary_out(ev_sum)
  );

  // Processor clock at 40 MHz.
  always #12.5 core_clk_in = ~core_clk_in;

  // A hung run is cut short well past the roughly 140 cycles the tests need.
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : tick

  task automatic wr(input dit_sel_t s, input dit_count_t d);
    @(posedge core_clk_in) wr_sel <= s;
    wr_data <= d;
    @(posedge core_clk_in) wr_sel <= DIT_SEL_NONE;
  endtask : wr

  task automatic rd(input dit_sel_t s, input dit_count_t e);
    @(posedge core_clk_in) rd_sel <= s;
    @(posedge core_clk_in);
    #1 chk(rd_data, e);
  endtask : rd

  // External clock at half the core rate, driven on core edges; it stands still between bursts.
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge core_clk_in) ext_clk_in <= 1'b1;
      @(posedge core_clk_in) ext_clk_in <= 1'b0;
    end
  endtask : ext_pulses

  task automatic test_reset_and_width;
    rd(DIT_SEL_A, 16'h0000);
    chk(16'(ev_sum), 16'h0000);
    wr(DIT_SEL_B, 16'ha5c3);
    rd(DIT_SEL_B, 16'ha5c3);
    rd(DIT_SEL_NONE, 16'h0000);
  endtask : test_reset_and_width

  // Timer b steps every core edge, so the timeout moment is exact.
  task automatic test_b_reload_clear;
    wr(DIT_SEL_B, 16'h0005);
    @(posedge core_clk_in) en_b <= 1'b1;
    tick(4);
    #1 chk(16'(ev[5]), 16'h0000);
    tick(1);
    #1 chk(16'(ev[5]), 16'h0001);
    tick(1);
    #1 chk(16'(ev_sum), 16'h0001);
    @(posedge core_clk_in) en_b <= 1'b0;
    rd(DIT_SEL_B, 16'h0003);
    chk(16'(ev[5]), 16'h0001);
    @(posedge core_clk_in) ev_clr <= 6'h20;
    @(posedge core_clk_in) ev_clr <= 6'h00;
    #1 chk(16'(ev[5]), 16'h0000);
    tick(20);
    rd(DIT_SEL_B, 16'h0003);
    chk(16'(ev), 16'h0000);
  endtask : test_b_reload_clear

  // Zero wraps to all ones, and a timeout beats a clear that lands in the same cycle.
  task automatic test_b_edges;
    wr(DIT_SEL_B, 16'h0000);
    @(posedge core_clk_in) en_b <= 1'b1;
    @(posedge core_clk_in) en_b <= 1'b0;
    rd(DIT_SEL_B, 16'hffff);
    chk(16'(ev[5]), 16'h0000);
    wr(DIT_SEL_B, 16'h0002);
    @(posedge core_clk_in) en_b <= 1'b1;
    @(posedge core_clk_in) ev_clr <= 6'h20;
    @(posedge core_clk_in) ev_clr <= 6'h00;
    en_b <= 1'b0;
    #1 chk(16'(ev[5]), 16'h0001);
    rd(DIT_SEL_B, 16'h0002);
    @(posedge core_clk_in) ev_clr <= 6'h20;
    @(posedge core_clk_in) ev_clr <= 6'h00;
    #1 chk(16'(ev), 16'h0000);
  endtask : test_b_edges

  // A reset in mid-run clears counts, events and the summary.
  task automatic test_mid_reset;
    wr(DIT_SEL_B, 16'h0001);
    @(posedge core_clk_in) en_b <= 1'b1;
    tick(2);
    #1 chk(16'(ev[5]), 16'h0001);
    chk(16'(ev_sum), 16'h0001);
    @(posedge core_clk_in) rst_b_in <= 1'b0;
    en_b <= 1'b0;
    tick(4);
    rst_b_in <= 1'b1;
    #1 chk(16'({ev_sum, ev}), 16'h0000);
    chk(rd_data, 16'h0000);
    rd(DIT_SEL_B, 16'h0000);
    rd(DIT_SEL_A, 16'h0000);
  endtask : test_mid_reset

  // The synchroniser must turn each slow edge into exactly one step.
  task automatic test_a_ext;
    @(posedge core_clk_in) en_a <= 1'b1;
    wr(DIT_SEL_A, 16'h000a);
    ext_pulses(4);
    tick(8);
    #1 chk(16'(ev[4]), 16'h0000);
    rd(DIT_SEL_A, 16'h0006);
    wr(DIT_SEL_A, 16'h0002);
    ext_pulses(2);
    tick(8);
    #1 chk(16'(ev[4]), 16'h0001);
    @(posedge core_clk_in) en_a <= 1'b0;
    rd(DIT_SEL_A, 16'h0002);
    @(posedge core_clk_in) ev_clr <= 6'h10;
    @(posedge core_clk_in) ev_clr <= 6'h00;
    #1 chk(16'(ev[4]), 16'h0000);
    ext_pulses(3);
    tick(8);
    rd(DIT_SEL_A, 16'h0002);
    chk(16'(ev[4]), 16'h0000);
  endtask : test_a_ext

  task automatic report_and_stop;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial begin
    tick(8);
    rst_b_in <= 1'b1;
    test_reset_and_width();
    test_b_reload_clear();
    test_b_edges();
    test_a_ext();
    test_mid_reset();
    report_and_stop();
  end
endmodule : test_dual_interval_timers
